// File: rtl/system_clock_source_control.sv
// Clock source control: oscillator control registers and system clock selection
//
// How it works
// [RL1] Every reset leaves the system clock on the internal oscillator divided by eight.
// [RL2] Divide select 00/01/10/11 divides the internal oscillator by 8/4/2/1.
// [RL3] Divide-by-eight is the reset value of the divide select field.
// [RL4] Internal control bit 7 enables the internal oscillator; it resets to 1.
// [RL5] Ready flag bit 6 is 1 only while the oscillator runs; bits 5..2 read 0.
// [RL6] Select bit 0 picks external (1) or divided internal (0); register resets to 0.
// [RL7] External oscillator ticks stay available to timers whichever source is selected.
// [RL8] Source may change while running; software selects only enabled, settled sources.
// [RL9] Internal oscillator is usable right after the write that enables it.
// [RL10] Mode field bits 6..4: off, CMOS, CMOS halved, RC, capacitor halved; 11x reserved.
// [RL11] Software sets frequency control bits 2..0 to match the external network.
// [RL12] Software skips the external clock pin in the crossbar and sets its input mode.
// [RL13] A calibration register trims the internal oscillator, loaded with a factory value.
// [RL14] Changing sources produces no runt or glitch on the system clock.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module system_clock_source_control #(
    parameter logic [7:0] CAL_DEFAULT = clock_control_pkg::CAL_FACTORY // Factory trim
) (
    input  wire logic                                  clk,              // 10 MHz block clock
    input  wire logic                                  rstn,             // Synchronous reset, active low
    input  wire logic [clock_control_pkg::ADDR_W-1:0]  address,          // Avalon byte address
    input  wire logic                                  read,             // Avalon read
    input  wire logic                                  write,            // Avalon write
    input  wire logic [clock_control_pkg::DATA_W-1:0]  writedata,        // Avalon write data
    input  wire logic [clock_control_pkg::BE_W-1:0]    byteenable,       // Avalon byte enables
    output logic      [clock_control_pkg::DATA_W-1:0]  readdata,         // Avalon read data
    output logic                                       waitrequest,      // Avalon wait request
    input  wire logic                                  intOscTick,       // Internal oscillator edge
    input  wire logic                                  extOscTick,       // Edge seen on ext_clock_pin
    output logic                                       sysClkTick,       // system_clock edge
    output logic                                       sysClkIsExt,      // Source now in use
    output logic                                       extClkTick,       // External clock to timers
    output logic                                       intOscEnable,     // Internal oscillator run
    output logic      [7:0]                            intOscCalibration,// Trim to the oscillator
    output logic      [2:0]                            extOscMode,       // Drive circuit mode
    output logic      [2:0]                            extOscFreqCtrl,   // Drive circuit range
    output logic                                       extPinAnalog      // Pin wants analog input
);
    import clock_control_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic       intOscEnable_r;                  // int_osc_enable
    logic [1:0] intOscDivideSel_r;               // int_osc_divide_sel
    logic       sysclkSourceSel_r;               // system_clock_source_sel
    logic [2:0] extOscMode_r;                    // ext_osc_mode
    logic [2:0] extOscFreqCtrl_r;                // ext_osc_freq_ctrl
    logic [7:0] intOscCalibration_r;             // int_osc_calibration
    logic       intOscReady_r;                   // int_osc_ready_flag

    // Bus handshake state
    logic                waitrequest_r;
    logic [DATA_W-1:0]   readdata_r;
    logic [DATA_W-1:0]   readdata_nxt;

    // Decoded bus signals
    logic       wordAligned;
    logic [7:0] regIndex;
    logic       upperZero;
    logic       wrAccept;
    logic       wrLow;
    logic       hitClkSel;
    logic       hitExtCtl;
    logic       hitIntCtl;
    logic       hitIntCal;

    // Clock path signals
    logic [2:0] intDivCount_r;
    logic [2:0] intDivMax;
    logic       intDivTick_r;
    logic       extHalfPhase_r;
    logic       extRunning;
    logic       extHalved;
    logic       extTick_r;
    logic       sysTick;
    logic       usingExt;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Byte address is four times the register index
    // Misaligned addresses hit nothing
    assign wordAligned = (address[1:0] == 2'h0);
    assign regIndex    = address[9:2];
    assign upperZero   = wordAligned;
    assign hitClkSel   = upperZero && (regIndex == IDX_CLOCK_SOURCE_SELECT);
    assign hitExtCtl   = upperZero && (regIndex == IDX_EXTCTL);
    assign hitIntCtl   = upperZero && (regIndex == IDX_INTCTL);
    assign hitIntCal   = upperZero && (regIndex == IDX_INTCAL);

    // A write lands on the edge where waitrequest is seen low
    assign wrAccept = write && !waitrequest_r;
    assign wrLow    = wrAccept && byteenable[0];

    // ------------------------------------------------------------
    // Avalon handshake: one wait cycle, then answer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            waitrequest_r <= 1'b1;
        end else if ((read || write) && waitrequest_r) begin
            waitrequest_r <= 1'b0;
        end else begin
            waitrequest_r <= 1'b1;
        end
    end

    // Read data image; unmapped and misaligned addresses read zero
    // Bits 31..8 read zero
    always_comb begin
        readdata_nxt = '0;
        if (hitClkSel) begin
            readdata_nxt[SRC_SEL_BIT] = sysclkSourceSel_r;          // RL6
        end else if (hitExtCtl) begin
            readdata_nxt[MODE_LSB +: 3] = extOscMode_r;             // RL10
            readdata_nxt[FREQ_LSB +: 3] = extOscFreqCtrl_r;
        end else if (hitIntCtl) begin
            readdata_nxt[INT_EN_BIT]  = intOscEnable_r;             // RL4
            readdata_nxt[INT_RDY_BIT] = intOscReady_r;              // RL5
            readdata_nxt[1:0]         = intOscDivideSel_r;
        end else if (hitIntCal) begin
            readdata_nxt[7:0] = intOscCalibration_r;                // RL13
        end
    end

    // Read data stand from the answering edge until the next read
    // Loaded as the request is seen
    always_ff @(posedge clk) begin
        if (!rstn) begin
            readdata_r <= '0;
        end else if (read && waitrequest_r) begin
            readdata_r <= readdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Internal oscillator control register
    // ------------------------------------------------------------

    // Enable and divide select; reset gives enabled, divide by eight
    // Bits 5..2 are not stored
    always_ff @(posedge clk) begin
        if (!rstn) begin
            intOscEnable_r    <= RST_INTCTL[INT_EN_BIT];            // RL4
            intOscDivideSel_r <= RST_INTCTL[1:0];                   // RL3
        end else if (wrLow && hitIntCtl) begin
            intOscEnable_r    <= writedata[INT_EN_BIT];             // RL4
            intOscDivideSel_r <= writedata[1:0];                    // RL2
        end
    end

    // Calibration trim, reloaded with the factory value on reset
    // A new trim clears ready unless an oscillator edge comes in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            intOscCalibration_r <= CAL_DEFAULT;                     // RL13
        end else if (wrLow && hitIntCal) begin
            intOscCalibration_r <= writedata[7:0];                  // RL13
        end
    end

    // Ready: enabled and an edge seen at the current trim
    // A tick beats a trim write
    always_ff @(posedge clk) begin
        if (!rstn) begin
            intOscReady_r <= 1'b0;
        end else if (!intOscEnable_r) begin
            intOscReady_r <= 1'b0;                                  // RL5
        end else if (intOscTick) begin
            intOscReady_r <= 1'b1;                                  // RL5
        end else if (wrLow && hitIntCal) begin
            intOscReady_r <= 1'b0;                                  // RL5
        end
    end

    // ------------------------------------------------------------
    // Clock select and external oscillator control registers
    // ------------------------------------------------------------

    // Source select; reserved bits are not stored
    // Select only a running source
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sysclkSourceSel_r <= RST_CLOCK_SOURCE_SELECT[SRC_SEL_BIT];           // RL6
        end else if (wrLow && hitClkSel) begin
            sysclkSourceSel_r <= writedata[SRC_SEL_BIT];            // RL8
        end
    end

    // External mode and frequency range; bits 7 and 3 read zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            extOscMode_r     <= RST_EXTCTL[MODE_LSB +: 3];
            extOscFreqCtrl_r <= RST_EXTCTL[FREQ_LSB +: 3];
        end else if (wrLow && hitExtCtl) begin
            extOscMode_r     <= writedata[MODE_LSB +: 3];           // RL10
            extOscFreqCtrl_r <= writedata[FREQ_LSB +: 3];           // RL11
        end
    end

    // ------------------------------------------------------------
    // Internal oscillator post-divider
    // ------------------------------------------------------------

    // Terminal count for the selected ratio
    // Count runs zero to this value
    always_comb begin
        unique case (intOscDivideSel_r)
            DIV_BY_8: intDivMax = 3'h7;                             // RL2
            DIV_BY_4: intDivMax = 3'h3;                             // RL2
            DIV_BY_2: intDivMax = 3'h1;                             // RL2
            DIV_BY_1: intDivMax = 3'h0;                             // RL2
        endcase
    end

    // Count oscillator edges; a stopped oscillator gives no ticks
    // Not cleared on a ratio change, so the
    // first new period may be short
    always_ff @(posedge clk) begin
        if (!rstn) begin
            intDivCount_r <= 3'h0;
            intDivTick_r  <= 1'b0;
        end else if (intOscEnable_r && intOscTick) begin
            if (intDivCount_r >= intDivMax) begin
                intDivCount_r <= 3'h0;                              // RL2
                intDivTick_r  <= 1'b1;
            end else begin
                intDivCount_r <= intDivCount_r + 3'h1;
                intDivTick_r  <= 1'b0;
            end
        end else begin
            intDivTick_r <= 1'b0;                                   // RL9
        end
    end

    // ------------------------------------------------------------
    // External oscillator path
    // ------------------------------------------------------------

    // Off for 00x and reserved 11x; halved for 011 and 101
    // Reserved modes behave as off
    assign extRunning = (extOscMode_r == MODE_CMOS) || (extOscMode_r == MODE_CMOS_2)
                     || (extOscMode_r == MODE_RC)   || (extOscMode_r == MODE_CAP);
    assign extHalved  = (extOscMode_r == MODE_CMOS_2) || (extOscMode_r == MODE_CAP);

    // Tick generation with the optional divide-by-two stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            extHalfPhase_r <= 1'b0;
            extTick_r      <= 1'b0;
        end else if (extRunning && extOscTick) begin
            extHalfPhase_r <= extHalved ? !extHalfPhase_r : 1'b0;   // RL10
            extTick_r      <= extHalved ? extHalfPhase_r : 1'b1;    // RL10
        end else begin
            extHalfPhase_r <= extRunning ? extHalfPhase_r : 1'b0;
            extTick_r      <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // System clock source switch
    // ------------------------------------------------------------
    // A dead new source stalls the change
    clock_source_switch u_switch (
        .clk        (clk),
        .rstn       (rstn),
        .intTick    (intDivTick_r),
        .extTick    (extTick_r),
        .selExt     (sysclkSourceSel_r),                            // RL6
        .sysTick_r  (sysTick),
        .usingExt_r (usingExt)
    );

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------

    // Clock ticks: system clock and the timer feed from the external side
    // Timers see ticks whatever the select
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sysClkTick  <= 1'b0;
            sysClkIsExt <= 1'b0;                                    // RL1
            extClkTick  <= 1'b0;
        end else begin
            sysClkTick  <= sysTick;                                 // RL14
            sysClkIsExt <= usingExt;
            extClkTick  <= extTick_r;                               // RL7
        end
    end

    // Control levels towards the analog oscillators
    // One cycle behind the fields
    always_ff @(posedge clk) begin
        if (!rstn) begin
            intOscEnable      <= RST_INTCTL[INT_EN_BIT];
            intOscCalibration <= CAL_DEFAULT;
            extOscMode        <= RST_EXTCTL[MODE_LSB +: 3];
            extOscFreqCtrl    <= RST_EXTCTL[FREQ_LSB +: 3];
            extPinAnalog      <= 1'b0;
        end else begin
            intOscEnable      <= intOscEnable_r;                    // RL4
            intOscCalibration <= intOscCalibration_r;               // RL13
            extOscMode        <= extOscMode_r;
            extOscFreqCtrl    <= extOscFreqCtrl_r;                  // RL11
            extPinAnalog      <= (extOscMode_r == MODE_RC) || (extOscMode_r == MODE_CAP); // RL12
        end
    end

    // Bus outputs straight from their flip-flops
    assign readdata    = readdata_r;
    assign waitrequest = waitrequest_r;

endmodule : system_clock_source_control
`default_nettype wire

// File: rtl/clock_control_pkg.sv
// Constants shared by the clock source control block
package clock_control_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 10;            // Byte address width
    localparam int          DATA_W      = 32;            // Avalon data width
    localparam int          BE_W        = 4;             // Byte enable width

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_CLOCK_SOURCE_SELECT  = 8'hA9;         // clock_source_select
    localparam logic [7:0]  IDX_EXTCTL  = 8'hB1;         // external_oscillator_control
    localparam logic [7:0]  IDX_INTCTL  = 8'hB2;         // internal_oscillator_control
    localparam logic [7:0]  IDX_INTCAL  = 8'hB3;         // int_osc_calibration

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CLOCK_SOURCE_SELECT  = 8'h00;
    localparam logic [7:0]  RST_EXTCTL  = 8'h00;
    localparam logic [7:0]  RST_INTCTL  = 8'hC0;
    localparam logic [7:0]  CAL_FACTORY = 8'h80;         // Default trim value, arbitrary

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          INT_EN_BIT  = 7;             // int_osc_enable
    localparam int          INT_RDY_BIT = 6;             // int_osc_ready_flag
    localparam int          SRC_SEL_BIT = 0;             // system_clock_source_sel
    localparam int          MODE_LSB    = 4;             // ext_osc_mode low bit
    localparam int          FREQ_LSB    = 0;             // ext_osc_freq_ctrl low bit

    // ------------------------------------------------------------
    // Divide select codes and external modes
    // ------------------------------------------------------------
    localparam logic [1:0]  DIV_BY_8    = 2'h0;
    localparam logic [1:0]  DIV_BY_4    = 2'h1;
    localparam logic [1:0]  DIV_BY_2    = 2'h2;
    localparam logic [1:0]  DIV_BY_1    = 2'h3;
    localparam logic [2:0]  MODE_CMOS   = 3'h2;
    localparam logic [2:0]  MODE_CMOS_2 = 3'h3;
    localparam logic [2:0]  MODE_RC     = 3'h4;
    localparam logic [2:0]  MODE_CAP    = 3'h5;

    // States of the source switcher
    typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_ARM} switch_state_t;

endpackage : clock_control_pkg

// File: rtl/clock_source_switch.sv
// Glitch-free changeover between two clock tick sources
`timescale 1ns/1ns
`default_nettype none
module clock_source_switch (
    input  wire logic clk,                   // Block clock
    input  wire logic rstn,                  // Synchronous reset, active low
    input  wire logic intTick,               // Divided internal source tick
    input  wire logic extTick,               // External source tick
    input  wire logic selExt,                // Requested source, 1 = external
    output logic      sysTick_r,             // system_clock tick
    output logic      usingExt_r             // Source now in use
);
    import clock_control_pkg::*;

    switch_state_t state_r;
    logic          oldTick;
    logic          newTick;

    // Tick of the source in use and of the one being requested
    assign oldTick = usingExt_r ? extTick : intTick;
    assign newTick = usingExt_r ? intTick : extTick;

    // ------------------------------------------------------------
    // Changeover sequence: finish old period, wait first new edge
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r    <= SW_RUN;
            usingExt_r <= 1'b0;                  // RL1
        end else begin
            unique case (state_r)
                SW_RUN: begin
                    if (selExt != usingExt_r) begin
                        state_r <= SW_DRAIN;     // RL8
                    end
                end
                SW_DRAIN: begin
                    if (selExt == usingExt_r) begin
                        state_r <= SW_RUN;
                    end else if (oldTick) begin
                        state_r <= SW_ARM;       // RL14
                    end
                end
                SW_ARM: begin
                    if (selExt == usingExt_r) begin
                        state_r <= SW_RUN;
                    end else if (newTick) begin
                        usingExt_r <= selExt;    // RL14
                        state_r    <= SW_RUN;
                    end
                end
            endcase
        end
    end

    // Output ticks never come from a half-finished period
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sysTick_r <= 1'b0;
        end else begin
            unique case (state_r)
                SW_RUN:   sysTick_r <= oldTick;
                SW_DRAIN: sysTick_r <= oldTick;
                SW_ARM:   sysTick_r <= (newTick && selExt != usingExt_r) ? 1'b1 : 1'b0; // RL14
            endcase
        end
    end

endmodule : clock_source_switch
`default_nettype wire

// File: testbench/clock_control_monitor.sv
// Port checks for the clock source control block
`timescale 1ns/1ns
`default_nettype none
module clock_control_monitor #(
    parameter logic [7:0] CAL_DEFAULT = 8'h80    // Trim after reset
) (
    input wire logic       clk,                  // Block clock
    input wire logic       rstn,                 // Reset, active low
    input wire logic       read,                 // Bus read
    input wire logic       write,                // Bus write
    input wire logic       waitrequest,          // Bus wait
    input wire logic       extOscTick,           // External tick in
    input wire logic       sysClkTick,           // System clock tick
    input wire logic       sysClkIsExt,          // Source in use
    input wire logic       extClkTick,           // Timer clock tick
    input wire logic       intOscEnable,         // Oscillator run
    input wire logic [7:0] intOscCalibration,    // Trim value
    input wire logic [2:0] extOscMode,           // External mode
    input wire logic       extPinAnalog          // Pin analog
);
    import clock_control_pkg::*;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_ack; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("bus request not answered");
    property p_pulse; !waitrequest |=> waitrequest; endproperty
    a_pulse: assert property (p_pulse) else $error("wait low for more than one cycle");
    property p_reset; $rose(rstn) |-> !sysClkIsExt && intOscEnable && waitrequest
        && intOscCalibration == CAL_DEFAULT && extOscMode == 3'h0; endproperty
    a_reset: assert property (p_reset) else $error("bad state after reset");
    property p_analog; extPinAnalog == (extOscMode == MODE_RC || extOscMode == MODE_CAP); endproperty
    a_analog: assert property (p_analog) else $error("pin analog mismatch");
    property p_timer; extOscTick ##1 extOscMode == MODE_CMOS |-> ##[0:2] extClkTick; endproperty
    a_timer: assert property (p_timer) else $error("timer clock tick missing");
    property p_off; (extOscMode[2:1] == 2'b00 || extOscMode[2:1] == 2'b11)[*4] |-> !extClkTick; endproperty
    a_off: assert property (p_off) else $error("tick while external is off");
    property p_switch; $changed(sysClkIsExt) |-> ##[0:3] sysClkTick
        or ##0 ($past(sysClkTick) || $past(sysClkTick, 2)); endproperty
    a_switch: assert property (p_switch) else $error("source change without tick");
    property p_stop; (!intOscEnable && !sysClkIsExt)[*4] |-> !sysClkTick; endproperty
    a_stop: assert property (p_stop) else $error("tick while oscillator off");
endmodule : clock_control_monitor
bind system_clock_source_control clock_control_monitor #(.CAL_DEFAULT(CAL_DEFAULT)) mon (.clk, .rstn,
    .read, .write, .waitrequest, .extOscTick, .sysClkTick, .sysClkIsExt, .extClkTick, .intOscEnable,
    .intOscCalibration, .extOscMode, .extPinAnalog);
`default_nettype wire

// File: testbench/system_clock_source_control_test.sv
// Self-checking bench for the clock source control block
`timescale 1ns/1ns
`default_nettype none
module system_clock_source_control_test;
    import clock_control_pkg::*;
    logic        clk, rstn, read, write, intOscTick, extOscTick = 1'b0, waitrequest;
    logic        sysClkTick, sysClkIsExt, extClkTick, intOscEnable, extPinAnalog;
    logic [9:0]  address;
    logic [31:0] writedata, readdata, rdata;
    logic [3:0]  byteenable;
    logic [7:0]  intOscCalibration;
    logic [2:0]  extOscMode, extOscFreqCtrl;
    logic [7:0]  modeTab [6] = '{8'h07, 8'h27, 8'h37, 8'h47, 8'h57, 8'h67};
    int          extTab [6] = '{0, 32, 16, 32, 16, 0};
    int          errorCnt, checkCount, cycles = 0, sysCnt, extCnt;
    system_clock_source_control dut (.clk, .rstn, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .intOscTick, .extOscTick, .sysClkTick, .sysClkIsExt, .extClkTick,
        .intOscEnable, .intOscCalibration, .extOscMode, .extOscFreqCtrl, .extPinAnalog);
    // Clock and external oscillator ticks, hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        extOscTick <= ~extOscTick;
        if (cycles > 6000) begin
            errorCnt++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic bus(logic wr, logic [7:0] idx, logic [31:0] d);
        @(posedge clk);
        address <= {idx, 2'b00};
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rd(string name, logic [7:0] idx, logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        chk(name, exp, rdata);
    endtask : rd
    task automatic count();
        sysCnt = 0;
        extCnt = 0;
        repeat (16) @(posedge clk);
        repeat (64) begin
            @(posedge clk);
            sysCnt += (sysClkTick !== 1'b0);
            extCnt += (extClkTick !== 1'b0);
        end
    endtask : count
    task report_and_stop();
        $display("Checks %0d mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {rstn, read, write, errorCnt, checkCount} = '0;
        {address, writedata} = '0;
        byteenable = 4'hF;
        intOscTick = 1'b1;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd("clock_source_select", IDX_CLOCK_SOURCE_SELECT, 32'h0000_0000);
        rd("extctl", IDX_EXTCTL, 32'h0000_0000);
        rd("intctl", IDX_INTCTL, 32'h0000_00C0);
        rd("cal", IDX_INTCAL, {24'h0, CAL_FACTORY});
        count();
        chk("reset rate", 32'h0000_0008, sysCnt);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, IDX_INTCTL, 32'h0000_0080 | c);
            count();
            chk("divided rate", 32'h0000_0008 << c, sysCnt);
        end
        bus(1'b1, IDX_INTCTL, 32'h0000_003F);
        rd("intctl off", IDX_INTCTL, 32'h0000_0003);
        count();
        chk("stopped rate", 32'h0000_0000, sysCnt);
        bus(1'b1, IDX_INTCTL, 32'h0000_0080);
        rd("intctl on", IDX_INTCTL, 32'h0000_00C0);
        bus(1'b1, IDX_INTCAL, 32'h0000_005A);
        rd("cal wr", IDX_INTCAL, 32'h0000_005A);
        chk("cal out", 32'h0000_005A, intOscCalibration);
        $display("test internal done");
        bus(1'b1, IDX_CLOCK_SOURCE_SELECT, 32'h0000_00FE);
        rd("clock_source_select rsv", IDX_CLOCK_SOURCE_SELECT, 32'h0000_0000);
        byteenable <= 4'hE;
        bus(1'b1, IDX_EXTCTL, 32'h0000_0023);
        byteenable <= 4'hF;
        rd("extctl be", IDX_EXTCTL, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_00FF);
        rd("unmapped", 8'h00, 32'h0000_0000);
        for (int m = 0; m < 6; m++) begin
            bus(1'b1, IDX_EXTCTL, {24'h0, modeTab[m]});
            rd("extctl", IDX_EXTCTL, {24'h0, modeTab[m]});
            count();
            chk("timer rate", extTab[m], extCnt);
            chk("freq", 32'h0000_0007, extOscFreqCtrl);
        end
        $display("test external modes done");
        bus(1'b1, IDX_EXTCTL, 32'h0000_0020);
        bus(1'b1, IDX_CLOCK_SOURCE_SELECT, 32'h0000_0001);
        count();
        chk("using ext", 32'h0000_0001, sysClkIsExt);
        chk("ext rate", 32'h0000_0020, sysCnt);
        chk("timer rate", 32'h0000_0020, extCnt);
        bus(1'b1, IDX_CLOCK_SOURCE_SELECT, 32'h0000_0000);
        count();
        chk("using int", 32'h0000_0000, sysClkIsExt);
        chk("int rate", 32'h0000_0008, sysCnt);
        $display("test switching done");
        rstn <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd("extctl", IDX_EXTCTL, 32'h0000_0000);
        rd("intctl", IDX_INTCTL, 32'h0000_00C0);
        rd("cal", IDX_INTCAL, {24'h0, CAL_FACTORY});
        $display("test second reset done");
        report_and_stop();
    end
endmodule : system_clock_source_control_test
`default_nettype wire
